// file: core/fp_round_pkg.sv
package fp_round_pkg;
   // ====================================================
   // rounding field encodings
   typedef enum logic [1:0] {
      rnd_nearest = 2'h0,
      rnd_down    = 2'h1,
      rnd_up      = 2'h2,
      rnd_zero    = 2'h3
   } rnd_mode_t;
   localparam logic [1:0] RND_RESET = 2'h0;
   localparam int LEG_RC_LO = 10;
   localparam int SIMD_RC_LO = 13;
   localparam logic [15:0] LEG_CTRL_RESET = 16'h037F;
   localparam logic [31:0] SIMD_CSR_RESET = 32'h0000_1F80;
   // ====================================================
   // destination formats
   typedef enum logic [2:0] {
      fmt_half   = 3'h0,
      fmt_single = 3'h1,
      fmt_double = 3'h2,
      fmt_ext    = 3'h3,
      fmt_int    = 3'h4
   } fmt_t;
   // ====================================================
   // operation classes
   typedef enum logic [2:0] {
      op_arith     = 3'h0,
      op_compare   = 3'h1,
      op_trunc_cvt = 3'h2,
      op_half_cvt  = 3'h3,
      op_half_arith = 3'h4
   } op_t;
   localparam int FRAC_W = 64;
   localparam int EXP_W = 16;
   // indefinite encodings, right aligned in an 80-bit result, one per format, half sharing the single pattern
   localparam logic [79:0] INDEF_SINGLE = 80'h0000_0000_0000_FFC0_0000;
   localparam logic [79:0] INDEF_DOUBLE = 80'h0000_FFF8_0000_0000_0000;
   localparam logic [79:0] INDEF_EXT = 80'hFFFF_C000_0000_0000_0000;
   localparam logic [79:0] INDEF_INT = 80'h0000_0000_0000_8000_0000;
endpackage : fp_round_pkg

// file: core/fp_rounding_control.sv
`timescale 1ns/1ps
module fp_rounding_control (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic leg_ctrl_we,
   input wire logic [15:0] leg_ctrl_wdata,
   input wire logic simd_csr_we,
   input wire logic [31:0] simd_csr_wdata,
   input wire logic in_valid,
   input wire logic in_simd,
   input wire fp_round_pkg::op_t in_op,
   input wire fp_round_pkg::fmt_t in_fmt,
   input wire logic in_sign,
   input wire logic [fp_round_pkg::EXP_W-1:0] in_exp,
   input wire logic [fp_round_pkg::FRAC_W+2:0] in_mant,
   input wire logic in_sticky,
   input wire logic in_nan,
   input wire logic in_masked_exc,
   output logic [15:0] leg_ctrl_q,
   output logic [31:0] simd_fp_ctrl_status_reg,
   output logic out_valid,
   output logic out_sign,
   output logic [fp_round_pkg::EXP_W-1:0] out_exp,
   output logic [fp_round_pkg::FRAC_W-1:0] out_mant,
   output logic out_indef,
   output logic [79:0] out_indef_bits,
   output logic out_quiet,
   output logic out_half_reject,
   output logic inexact_flag
);
   import fp_round_pkg::*;

   // ====================================================
   // reset synchroniser
   logic rst_m_q, rst_s_q;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rst_m_q <= 1'b0;
         rst_s_q <= 1'b0;
      end else begin
         rst_m_q <= 1'b1;
         rst_s_q <= rst_m_q;
      end
   end

   // ====================================================
   // control registers, each field owned by one unit
   logic [31:0] simd_csr_q;
   always_ff @(posedge mclk or negedge rst_s_q) begin
      if (!rst_s_q) begin
         leg_ctrl_q <= LEG_CTRL_RESET;
      end else if (leg_ctrl_we) begin
         leg_ctrl_q <= leg_ctrl_wdata;
      end
   end
   always_ff @(posedge mclk or negedge rst_s_q) begin
      if (!rst_s_q) begin
         simd_csr_q <= SIMD_CSR_RESET;
      end else if (simd_csr_we) begin
         simd_csr_q <= simd_csr_wdata;
      end
   end
   assign simd_fp_ctrl_status_reg = simd_csr_q;

   // ====================================================
   // select the active two-bit field
   rnd_mode_t rounding_select_field;
   always_comb begin
      if (in_op == op_trunc_cvt) begin
         rounding_select_field = rnd_zero;
      end else if (in_simd) begin
         rounding_select_field = rnd_mode_t'(simd_csr_q[SIMD_RC_LO +: 2]);
      end else begin
         rounding_select_field = rnd_mode_t'(leg_ctrl_q[LEG_RC_LO +: 2]);
      end
   end

   // ====================================================
   // increment decision; guard = bit 2, round = bit 1, low bit 0 + sticky
   function automatic logic round_up_f(input rnd_mode_t m, input logic s, input logic lsb,
                                       input logic g, input logic rest);
      unique case (m)
         rnd_nearest: round_up_f = g & (rest | lsb);
         rnd_down: round_up_f = s & (g | rest);
         rnd_up: round_up_f = ~s & (g | rest);
         rnd_zero: round_up_f = 1'b0;
      endcase
   endfunction : round_up_f

   logic guard, rest, lost, inc;
   logic [FRAC_W:0] sum;
   assign guard = in_mant[2];
   assign rest = in_mant[1] | in_mant[0] | in_sticky;
   assign lost = guard | rest;
   assign inc = lost & round_up_f(rounding_select_field, in_sign, in_mant[3], guard, rest);
   assign sum = {1'b0, in_mant[FRAC_W+2:3]} + {{FRAC_W{1'b0}}, inc};

   logic exact_pass, half_bad;
   assign half_bad = (in_op == op_half_arith);
   assign exact_pass = in_nan | (in_op == op_compare) | ~lost;

   function automatic logic [79:0] indef_f(input fmt_t f);
      unique case (f)
         fmt_single, fmt_half: indef_f = INDEF_SINGLE;
         fmt_double: indef_f = INDEF_DOUBLE;
         fmt_ext: indef_f = INDEF_EXT;
         default: indef_f = INDEF_INT;
      endcase
   endfunction : indef_f

   // ====================================================
   // registered result
   always_ff @(posedge mclk or negedge rst_s_q) begin
      if (!rst_s_q) begin
         out_valid <= 1'b0;
         out_sign <= 1'b0;
         out_exp <= '0;
         out_mant <= '0;
         out_indef <= 1'b0;
         out_indef_bits <= '0;
         out_quiet <= 1'b0;
         out_half_reject <= 1'b0;
         inexact_flag <= 1'b0;
      end else begin
         out_valid <= in_valid;
         out_half_reject <= in_valid & half_bad;
         out_indef <= in_valid & in_masked_exc;
         out_indef_bits <= indef_f(in_fmt);
         out_quiet <= in_nan & in_mant[FRAC_W+1];
         out_sign <= in_sign;
         if (exact_pass) begin
            out_exp <= in_exp;
            out_mant <= in_mant[FRAC_W+2:3];
         end else if (sum[FRAC_W]) begin
            out_exp <= in_exp + 16'h0001; // mantissa carried out
            out_mant <= sum[FRAC_W:1];
         end else begin
            out_exp <= in_exp;
            out_mant <= sum[FRAC_W-1:0];
         end
         inexact_flag <= in_valid & ~exact_pass & ~in_masked_exc;
      end
   end

   // ====================================================
   // checks
   // truncating conversions never increment, whatever the field holds
   a_trunc_no_inc: assert property (@(posedge mclk) disable iff (!rst_s_q)
      (in_op == op_trunc_cvt) |-> !inc) else $error("truncation incremented");

   // exact results never raise the flag
   a_exact_no_flag: assert property (@(posedge mclk) disable iff (!rst_s_q)
      (in_valid && !lost) |=> !inexact_flag) else $error("exact result flagged");

   // lost bits on a plain rounded result must raise the flag
   a_inexact_flag: assert property (@(posedge mclk) disable iff (!rst_s_q)
      (in_valid && lost && !in_nan && in_op != op_compare && !in_masked_exc) |=> inexact_flag)
      else $error("inexact not flagged");

   // chop mode keeps the lower magnitude
   a_rz_no_inc: assert property (@(posedge mclk) disable iff (!rst_s_q)
      (rounding_select_field == rnd_zero) |-> !inc) else $error("zero mode incremented");

   // exact half way: increment only when the kept lsb is odd
   a_tie_even: assert property (@(posedge mclk) disable iff (!rst_s_q)
      (rounding_select_field == rnd_nearest && guard && !rest) |-> (inc == in_mant[3]))
      else $error("tie not to even");

   // toward minus infinity never grows a positive magnitude
   a_down_sign: assert property (@(posedge mclk) disable iff (!rst_s_q)
      (rounding_select_field == rnd_down && !in_sign) |-> !inc) else $error("down rounded up");

   // toward plus infinity never grows a negative magnitude
   a_up_sign: assert property (@(posedge mclk) disable iff (!rst_s_q)
      (rounding_select_field == rnd_up && in_sign) |-> !inc) else $error("up rounded wrong");

   // masked exception marks the result as indefinite
   a_indef_out: assert property (@(posedge mclk) disable iff (!rst_s_q)
      (in_valid && in_masked_exc) |=> out_indef) else $error("indefinite missing");

   // pass-through keeps the mantissa bit for bit
   a_exact_pass: assert property (@(posedge mclk) disable iff (!rst_s_q)
      (in_valid && exact_pass) |=> (out_mant == $past(in_mant[FRAC_W+2:3])))
      else $error("exact value altered");

   // ====================================================
   // issue steps used by the result checks below
   sequence s_masked_issue;
      in_valid && in_masked_exc;
   endsequence
   sequence s_half_issue;
      in_valid && half_bad;
   endsequence
   sequence s_nan_issue;
      in_valid && in_nan;
   endsequence
   sequence s_quiet_issue;
      in_valid && in_nan && in_mant[FRAC_W+1];
   endsequence
   sequence s_carry_issue;
      in_valid && !exact_pass && sum[FRAC_W];
   endsequence

   // one answer per operand, a cycle later, no stall
   a_valid_follows: assert property (@(posedge mclk) disable iff (!rst_s_q)
      in_valid |=> out_valid) else $error("result valid missing");

   // no answer without an operand
   a_valid_idle: assert property (@(posedge mclk) disable iff (!rst_s_q)
      !in_valid |=> !out_valid) else $error("spurious result valid");

   // half arithmetic is refused, flagged beside the result
   a_half_reject: assert property (@(posedge mclk) disable iff (!rst_s_q)
      s_half_issue |=> out_half_reject) else $error("half arith not refused");

   // half to single conversion is a legal operation
   a_half_cvt_ok: assert property (@(posedge mclk) disable iff (!rst_s_q)
      (in_valid && in_op == op_half_cvt) |=> !out_half_reject)
      else $error("half conversion refused");

   // single, double and extended each carry their own reserved pattern
   a_indef_single: assert property (@(posedge mclk) disable iff (!rst_s_q)
      (in_valid && in_masked_exc && in_fmt == fmt_single) |=> (out_indef_bits == INDEF_SINGLE))
      else $error("single indefinite wrong");

   a_indef_double: assert property (@(posedge mclk) disable iff (!rst_s_q)
      (in_valid && in_masked_exc && in_fmt == fmt_double) |=> (out_indef_bits == INDEF_DOUBLE))
      else $error("double indefinite wrong");

   a_indef_ext: assert property (@(posedge mclk) disable iff (!rst_s_q)
      (in_valid && in_masked_exc && in_fmt == fmt_ext) |=> (out_indef_bits == INDEF_EXT))
      else $error("extended indefinite wrong");

   // masked response replaces the value, so no precision flag
   a_masked_no_flag: assert property (@(posedge mclk) disable iff (!rst_s_q)
      s_masked_issue |=> !inexact_flag) else $error("masked result flagged");

   // top fraction bit set means quiet
   a_quiet_nan: assert property (@(posedge mclk) disable iff (!rst_s_q)
      s_quiet_issue |=> out_quiet) else $error("quiet nan missed");

   // top fraction bit clear means signaling
   a_signal_nan: assert property (@(posedge mclk) disable iff (!rst_s_q)
      (in_nan && !in_mant[FRAC_W+1]) |=> !out_quiet) else $error("signaling seen quiet");

   // nan results ignore the mode entirely
   a_nan_no_flag: assert property (@(posedge mclk) disable iff (!rst_s_q)
      s_nan_issue |=> !inexact_flag) else $error("nan result flagged");

   // compares ignore the mode entirely
   a_cmp_no_flag: assert property (@(posedge mclk) disable iff (!rst_s_q)
      (in_valid && in_op == op_compare) |=> !inexact_flag)
      else $error("compare flagged");

   // legacy operations read only the legacy field
   a_leg_field: assert property (@(posedge mclk) disable iff (!rst_s_q)
      (!in_simd && in_op != op_trunc_cvt) |->
      (rounding_select_field == leg_ctrl_q[LEG_RC_LO +: 2]))
      else $error("legacy field not used");

   // simd operations read only the simd field
   a_simd_field: assert property (@(posedge mclk) disable iff (!rst_s_q)
      (in_simd && in_op != op_trunc_cvt) |->
      (rounding_select_field == simd_csr_q[SIMD_RC_LO +: 2]))
      else $error("simd field not used");

   // truncating conversions override either field
   a_trunc_mode: assert property (@(posedge mclk) disable iff (!rst_s_q)
      (in_op == op_trunc_cvt) |-> (rounding_select_field == rnd_zero))
      else $error("truncation mode lost");

   // below half way nearest keeps the lower neighbour
   a_near_below: assert property (@(posedge mclk) disable iff (!rst_s_q)
      (rounding_select_field == rnd_nearest && !guard) |-> !inc)
      else $error("nearest rounded up early");

   // above half way nearest takes the upper neighbour
   a_near_above: assert property (@(posedge mclk) disable iff (!rst_s_q)
      (rounding_select_field == rnd_nearest && guard && rest) |-> inc)
      else $error("nearest missed upper");

   // negative inexact toward minus infinity grows the magnitude
   a_down_inc: assert property (@(posedge mclk) disable iff (!rst_s_q)
      (rounding_select_field == rnd_down && in_sign && lost) |-> inc)
      else $error("down missed lower");

   // positive inexact toward plus infinity grows the magnitude
   a_up_inc: assert property (@(posedge mclk) disable iff (!rst_s_q)
      (rounding_select_field == rnd_up && !in_sign && lost) |-> inc)
      else $error("up missed upper");

   // nothing lost means nothing added
   a_no_loss_inc: assert property (@(posedge mclk) disable iff (!rst_s_q)
      !lost |-> !inc) else $error("exact value incremented");

   // mantissa carry renormalises into the exponent
   a_carry_exp: assert property (@(posedge mclk) disable iff (!rst_s_q)
      s_carry_issue |=> (out_exp == $past(in_exp) + 16'h0001))
      else $error("carry exponent wrong");

   // a field changes only on its own write strobe
   a_leg_hold: assert property (@(posedge mclk) disable iff (!rst_s_q)
      !leg_ctrl_we |=> $stable(leg_ctrl_q)) else $error("legacy field disturbed");

   a_simd_hold: assert property (@(posedge mclk) disable iff (!rst_s_q)
      !simd_csr_we |=> $stable(simd_csr_q)) else $error("simd field disturbed");

   // a write lands whole on the next edge
   a_leg_write: assert property (@(posedge mclk) disable iff (!rst_s_q)
      leg_ctrl_we |=> (leg_ctrl_q == $past(leg_ctrl_wdata)))
      else $error("legacy write lost");

   a_simd_write: assert property (@(posedge mclk) disable iff (!rst_s_q)
      simd_csr_we |=> (simd_csr_q == $past(simd_csr_wdata)))
      else $error("simd write lost");
endmodule : fp_rounding_control

// file: tb/fp_issue_model.sv
`timescale 1ns/1ps
module fp_issue_model (
   input wire logic mclk,
   output logic leg_ctrl_we,
   output logic [15:0] leg_ctrl_wdata,
   output logic simd_csr_we,
   output logic [31:0] simd_csr_wdata,
   output logic in_valid,
   output logic in_simd,
   output fp_round_pkg::op_t in_op,
   output fp_round_pkg::fmt_t in_fmt,
   output logic in_sign,
   output logic [fp_round_pkg::EXP_W-1:0] in_exp,
   output logic [fp_round_pkg::FRAC_W+2:0] in_mant,
   output logic in_sticky,
   output logic in_nan,
   output logic in_masked_exc
);
   import fp_round_pkg::*;
   // =========================================
   // issue side: quiet at time zero
   initial begin
      {leg_ctrl_we, simd_csr_we, in_valid, in_simd, in_sign, in_sticky, in_nan} = '0;
      {in_masked_exc, leg_ctrl_wdata, simd_csr_wdata, in_exp, in_mant} = '0;
      in_op = op_arith;
      in_fmt = fmt_ext;
   end
   // one-cycle write pulse into both control words, other bits at reset value
   task automatic set_modes(input logic [1:0] leg, input logic [1:0] simd);
      @(posedge mclk);
      leg_ctrl_we <= 1'b1;
      simd_csr_we <= 1'b1;
      leg_ctrl_wdata <= (LEG_CTRL_RESET & 16'hF3FF) | (16'(leg) << LEG_RC_LO);
      simd_csr_wdata <= (SIMD_CSR_RESET & 32'hFFFF_9FFF) | (32'(simd) << SIMD_RC_LO);
      @(posedge mclk);
      leg_ctrl_we <= 1'b0;
      simd_csr_we <= 1'b0;
   endtask : set_modes
   // one operand; afterwards the mantissa and sticky lines flip so stale data is never reused
   task automatic send(input logic u, input op_t op, input fmt_t f, input logic s,
                       input logic [66:0] v, input logic st, input logic nan, input logic exc);
      @(posedge mclk);
      {in_valid, in_simd, in_sign, in_sticky, in_nan, in_masked_exc} <= {1'b1, u, s, st, nan, exc};
      in_op <= op;
      in_fmt <= f;
      in_mant <= v;
      in_exp <= 16'h3FFF;
      @(posedge mclk);
      in_valid <= 1'b0;
      in_mant <= ~v;
      in_sticky <= ~st;
   endtask : send
endmodule : fp_issue_model

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   import fp_round_pkg::*;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   int failures = 0;
   int total_checks = 0;
   logic leg_ctrl_we, simd_csr_we, in_valid, in_simd, in_sign, in_sticky, in_nan, in_masked_exc;
   logic [15:0] leg_ctrl_wdata, leg_ctrl_q;
   logic [31:0] simd_csr_wdata, simd_fp_ctrl_status_reg;
   op_t in_op;
   fmt_t in_fmt;
   logic [EXP_W-1:0] in_exp, out_exp;
   logic [FRAC_W+2:0] in_mant, v;
   logic [FRAC_W-1:0] out_mant, exp_mant;
   logic [79:0] out_indef_bits;
   logic out_valid, out_sign, out_indef, out_quiet, out_half_reject, inexact_flag, exp_inx;
   fmt_t fl[4] = '{fmt_single, fmt_double, fmt_ext, fmt_int};
   logic [79:0] il[4] = '{INDEF_SINGLE, INDEF_DOUBLE, INDEF_EXT, INDEF_INT};
   always #5 mclk = ~mclk;
   fp_issue_model i_model (.mclk, .leg_ctrl_we, .leg_ctrl_wdata, .simd_csr_we, .simd_csr_wdata,
      .in_valid, .in_simd, .in_op, .in_fmt, .in_sign, .in_exp, .in_mant, .in_sticky, .in_nan,
      .in_masked_exc);
   fp_rounding_control i_dut (.mclk, .rst_b, .leg_ctrl_we, .leg_ctrl_wdata, .simd_csr_we,
      .simd_csr_wdata, .in_valid, .in_simd, .in_op, .in_fmt, .in_sign, .in_exp, .in_mant,
      .in_sticky, .in_nan, .in_masked_exc, .leg_ctrl_q, .simd_fp_ctrl_status_reg, .out_valid,
      .out_sign, .out_exp, .out_mant, .out_indef, .out_indef_bits, .out_quiet, .out_half_reject,
      .inexact_flag);
   // =========================================
   // reference rounding: returns {inexact, mantissa}; carry-out cases avoided
   function automatic logic [64:0] rnd(input logic [1:0] m, input logic s, input logic [66:0] x,
                                       input logic st);
      logic inx;
      logic up;
      inx = |x[2:0] | st;
      case (m)
         2'h0: up = x[2] & (x[1] | x[0] | st | x[3]);
         2'h1: up = s & inx;
         2'h2: up = ~s & inx;
         default: up = 1'b0;
      endcase
      return {inx, x[66:3] + 64'(up)};
   endfunction : rnd
   task automatic chk(input logic [79:0] got, input logic [79:0] expv);
      total_checks++;
      if (got !== expv) begin
         failures++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, expv);
      end
   endtask : chk
   task automatic run(input logic u, input op_t op, input fmt_t f, input logic s,
                      input logic st, input logic nan, input logic exc);
      i_model.send(u, op, f, s, v, st, nan, exc);
      @(negedge mclk);
      chk(80'(out_valid), 80'h1);
   endtask : run
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : summarize
   // =========================================
   // main sequence; legacy gets mode m, simd the opposite one to prove independence
   initial begin
      repeat (16) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (4) @(negedge mclk);
      chk(80'(leg_ctrl_q), 80'(LEG_CTRL_RESET));
      chk(80'(simd_fp_ctrl_status_reg), 80'(SIMD_CSR_RESET));
      for (int m = 0; m < 4; m++) begin
         i_model.set_modes(2'(m), 2'(3 - m));
         @(negedge mclk);
         chk(80'(leg_ctrl_q[11:10]), 80'(m));
         chk(80'(simd_fp_ctrl_status_reg[14:13]), 80'(3 - m));
         for (int k = 0; k < 128; k++) begin
            v = {63'h4000_0000_0000_0000, k[2], k[5:3]};
            {exp_inx, exp_mant} = rnd(k[0] ? 2'(3 - m) : 2'(m), k[1], v, k[6]);
            run(k[0], op_arith, fmt_ext, k[1], k[6], 1'b0, 1'b0);
            chk(80'(out_mant), 80'(exp_mant));
            chk(80'(inexact_flag), 80'(exp_inx));
            chk(80'({out_sign, out_exp}), 80'({k[1], 16'h3FFF}));
         end
      end
      $display("test rounding modes done");
      // round-up selected, yet these must not round; only the truncation raises the flag
      i_model.set_modes(2'h2, 2'h2);
      v = {63'h4000_0000_0000_0000, 4'h6};
      run(1'b1, op_trunc_cvt, fmt_ext, 1'b0, 1'b1, 1'b0, 1'b0);
      chk(80'({inexact_flag, out_mant}), 80'({1'b1, v[66:3]}));
      run(1'b1, op_compare, fmt_ext, 1'b0, 1'b1, 1'b0, 1'b0);
      chk(80'(inexact_flag), 80'h0);
      run(1'b0, op_arith, fmt_ext, 1'b0, 1'b1, 1'b1, 1'b0);
      chk(80'(inexact_flag), 80'h0);
      chk(80'({out_quiet, out_mant}), 80'({1'b0, v[66:3]}));
      v = {3'h3, 64'h0000_0000_0000_0000};
      run(1'b0, op_arith, fmt_ext, 1'b0, 1'b0, 1'b1, 1'b0);
      chk(80'({out_quiet, out_mant}), 80'({1'b1, v[66:3]}));
      // all-ones mantissa rounded up carries into the exponent
      v = {64'hFFFF_FFFF_FFFF_FFFF, 3'h1};
      run(1'b0, op_arith, fmt_ext, 1'b0, 1'b0, 1'b0, 1'b0);
      chk(80'(out_mant), 80'(64'h8000_0000_0000_0000));
      chk(80'({inexact_flag, out_exp}), 80'({1'b1, 16'h4000}));
      $display("test mode-immune ops done");
      for (int i = 0; i < 4; i++) begin
         run(i[0], op_arith, fl[i], 1'b0, 1'b0, 1'b0, 1'b1);
         chk(out_indef_bits, il[i]);
         chk(80'({out_indef, inexact_flag}), 80'h2);
      end
      run(1'b1, op_half_arith, fmt_half, 1'b0, 1'b0, 1'b0, 1'b0);
      chk(80'(out_half_reject), 80'h1);
      run(1'b1, op_half_cvt, fmt_single, 1'b0, 1'b0, 1'b0, 1'b0);
      chk(80'(out_half_reject), 80'h0);
      $display("test indefinite and half done");
      summarize();
   end
   // watchdog: the whole run needs about 1100 cycles
   initial begin
      #100000;
      failures++;
      summarize();
   end
endmodule : testbench
